// ===== verilog/fps_top.v
// Purpose: flash protection register and command status flags
// Assumes: sequencer reports command done; flash word writes arrive as pulses
// Notes: protection loads from nvm_prot on the first cycle after reset
`include "fps_map.vh"

module fps_top #(
   parameter AW = 16,
   parameter RAW = 4
) (
   input wire clock,
   input wire rstn,
   input wire special_mode,
   input wire [7:0] nvm_prot,
   input wire [RAW-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire flash_wr,
   input wire [AW-1:0] flash_wr_addr,
   input wire cmd_done,
   input wire verify_blank,
   output reg cmd_start,
   output reg [AW-1:0] cmd_start_addr,
   output reg [2:0] scenario,
   output reg irq_buf_empty,
   output reg irq_cmd_complete
);

   // ****************************************
   // scenario table
   // ****************************************

   function [2:0] scen_of;
      input open_b;
      input hoff_b;
      input loff_b;
      begin
         case ({open_b, hoff_b, loff_b})
            3'b111: scen_of = 3'd7;
            3'b110: scen_of = 3'd5;
            3'b101: scen_of = 3'd6;
            3'b100: scen_of = 3'd4;
            3'b011: scen_of = 3'd3;
            3'b001: scen_of = 3'd2;
            3'b010: scen_of = 3'd1;
            default: scen_of = 3'd0;
         endcase
      end
   endfunction

   function trans_ok;
      input [2:0] from_s;
      input [2:0] to_s;
      reg [63:0] tbl;
      begin
         tbl = `FPS_TRANS_OK;
         trans_ok = tbl[{from_s, to_s}];
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg [7:0] prot_q;
   reg [7:0] prot_d;
   reg load_q;
   reg [1:0] cfg_q;
   reg be_q;
   reg cc_q;
   reg pv_q;
   reg ae_q;
   reg blank_q;
   reg fail_q;
   reg seq_q;
   reg [AW-1:0] seq_addr_q;
   reg active_q;
   reg pend_q;
   reg [AW-1:0] pend_addr_q;
   wire addr_prot;
   wire wr_prot;
   wire wr_stat;
   wire wr_cfg;
   wire launch_try;
   wire err_any;
   wire launch_ok;
   wire launch_viol;
   wire abort_seq;
   wire seq_start;
   wire fetch_pend;
   reg [2:0] scen_new;
   reg cand_ok;

   assign wr_prot = reg_wr && (reg_addr == `FPS_OFS_PROTECT);
   assign wr_stat = reg_wr && (reg_addr == `FPS_OFS_STATUS);
   assign wr_cfg = reg_wr && (reg_addr == `FPS_OFS_CONFIG);

   // ****************************************
   // address check
   // ****************************************

   // protection test on the buffered word address
   fps_prot_dec #(
      .AW(AW)
   ) u_dec (
      .open_polarity(prot_q[`FPS_PR_OPEN]),
      .high_range_off(prot_q[`FPS_PR_HOFF]),
      .high_size_sel(prot_q[`FPS_PR_HS_HI:`FPS_PR_HS_LO]),
      .low_range_off(prot_q[`FPS_PR_LOFF]),
      .low_size_sel(prot_q[`FPS_PR_LS_HI:`FPS_PR_LS_LO]),
      .addr(seq_addr_q),
      .is_protected(addr_prot)
   );

   // ****************************************
   // protect register write filter
   // ****************************************

   // build candidate, then check the scenario move
   always @* begin
      prot_d = reg_wdata;
      // size fields follow their off bit
      if (!prot_q[`FPS_PR_HOFF]) begin
         prot_d[`FPS_PR_HS_HI:`FPS_PR_HS_LO] = prot_q[`FPS_PR_HS_HI:`FPS_PR_HS_LO];
      end
      if (!prot_q[`FPS_PR_LOFF]) begin
         prot_d[`FPS_PR_LS_HI:`FPS_PR_LS_LO] = prot_q[`FPS_PR_LS_HI:`FPS_PR_LS_LO];
      end
      scen_new = scen_of(prot_d[`FPS_PR_OPEN], prot_d[`FPS_PR_HOFF], prot_d[`FPS_PR_LOFF]);
      cand_ok = trans_ok(scenario, scen_new);
   end

   // load from array, then honour software
   always @(posedge clock) begin
      if (!rstn) begin
         prot_q <= `FPS_RST_PROTECT;
         load_q <= 1'b1;
      end else if (load_q) begin
         prot_q <= nvm_prot;
         load_q <= 1'b0;
      end else if (wr_prot && cand_ok) begin
         prot_q <= prot_d;
      end
   end

   // scenario in force, kept beside the register
   always @(posedge clock) begin
      if (!rstn) begin
         scenario <= 3'd7;
      end else if (load_q) begin
         scenario <= scen_of(nvm_prot[`FPS_PR_OPEN], nvm_prot[`FPS_PR_HOFF],
            nvm_prot[`FPS_PR_LOFF]);
      end else if (wr_prot && cand_ok) begin
         scenario <= scen_new;
      end
   end

   // ****************************************
   // config register
   // ****************************************

   localparam [7:0] CFG_RST = `FPS_RST_CONFIG; // only the two enable bits are kept
   // interrupt enables
   always @(posedge clock) begin
      if (!rstn) begin
         cfg_q <= CFG_RST[`FPS_CF_BEIE:`FPS_CF_CMD_COMPLETE_IRQ_EN];
      end else if (wr_cfg) begin
         cfg_q <= reg_wdata[`FPS_CF_BEIE:`FPS_CF_CMD_COMPLETE_IRQ_EN];
      end
   end

   // ****************************************
   // command write sequence
   // ****************************************

   // fail only blocks launches in special modes
   assign err_any = pv_q || ae_q || (special_mode && fail_q);
   assign launch_try = wr_stat && reg_wdata[`FPS_ST_BE] && be_q;
   assign launch_ok = launch_try && seq_q && !err_any && !addr_prot;
   assign launch_viol = launch_try && seq_q && !err_any && addr_prot;
   assign abort_seq = wr_stat && !reg_wdata[`FPS_ST_BE] && seq_q;
   assign seq_start = flash_wr && be_q && !seq_q;
   assign fetch_pend = cmd_done && pend_q;

   // sequence tracking: one buffered word address
   always @(posedge clock) begin
      if (!rstn) begin
         seq_q <= 1'b0;
         seq_addr_q <= {AW{1'b0}};
      end else if (launch_try || abort_seq) begin
         seq_q <= 1'b0;
      end else if (seq_start) begin
         seq_q <= 1'b1;
         seq_addr_q <= flash_wr_addr;
      end
   end

   // ****************************************
   // command engine hand-off
   // ****************************************

   // one active and one pending slot
   always @(posedge clock) begin
      if (!rstn) begin
         active_q <= 1'b0;
         pend_q <= 1'b0;
         pend_addr_q <= {AW{1'b0}};
         cmd_start <= 1'b0;
         cmd_start_addr <= {AW{1'b0}};
      end else begin
         cmd_start <= 1'b0;
         if (launch_ok && (!active_q || cmd_done) && !pend_q) begin
            active_q <= 1'b1;
            cmd_start <= 1'b1;
            cmd_start_addr <= seq_addr_q;
         end else if (fetch_pend) begin
            // pending word moves up, a new launch may refill
            cmd_start <= 1'b1;
            cmd_start_addr <= pend_addr_q;
            pend_q <= launch_ok;
            pend_addr_q <= seq_addr_q;
         end else if (launch_ok) begin
            pend_q <= 1'b1;
            pend_addr_q <= seq_addr_q;
         end else if (cmd_done) begin
            active_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // status flags
   // ****************************************

   // buffer empty: launch clears, free slot sets
   always @(posedge clock) begin
      if (!rstn) begin
         be_q <= 1'b1;
      end else if (launch_ok) begin
         be_q <= 1'b0;
      end else if (!be_q && !pend_q) begin
         be_q <= 1'b1;
      end else if (fetch_pend) begin
         be_q <= 1'b1;
      end
   end

   // complete only when nothing runs or waits
   always @(posedge clock) begin
      if (!rstn) begin
         cc_q <= 1'b1;
      end else if (!be_q || launch_ok) begin
         cc_q <= 1'b0;
      end else if (fetch_pend) begin
         cc_q <= 1'b0;
      end else if (cmd_done && active_q) begin
         cc_q <= 1'b1;
      end else if (!active_q && !pend_q) begin
         cc_q <= 1'b1;
      end
   end

   always @(posedge clock) begin
      if (!rstn) begin
         pv_q <= 1'b0;
      end else if (launch_viol) begin
         pv_q <= 1'b1;
      end else if (wr_stat && reg_wdata[`FPS_ST_PV]) begin
         pv_q <= 1'b0;
      end
   end

   // access error from sequence faults; set wins
   always @(posedge clock) begin
      if (!rstn) begin
         ae_q <= 1'b0;
      end else if (abort_seq || (launch_try && !seq_q)) begin
         ae_q <= 1'b1;
      end else if (wr_stat && reg_wdata[`FPS_ST_AE]) begin
         ae_q <= 1'b0;
      end
   end

   // blank result cleared by a new launch
   always @(posedge clock) begin
      if (!rstn) begin
         blank_q <= 1'b0;
      end else if (cmd_done && active_q) begin
         blank_q <= verify_blank;
      end else if (launch_ok) begin
         blank_q <= 1'b0;
      end
   end

   always @(posedge clock) begin
      if (!rstn) begin
         fail_q <= 1'b0;
      end else if (special_mode && cmd_done && active_q && !verify_blank) begin
         fail_q <= 1'b1;
      end else if (special_mode && wr_stat && reg_wdata[`FPS_ST_FAIL]) begin
         fail_q <= 1'b0;
      end
   end

   // ****************************************
   // interrupt requests
   // ****************************************

   // registered requests from flag and enable
   always @(posedge clock) begin
      if (!rstn) begin
         irq_buf_empty <= 1'b0;
         irq_cmd_complete <= 1'b0;
      end else begin
         irq_buf_empty <= be_q && cfg_q[1];
         irq_cmd_complete <= cc_q && cfg_q[0];
      end
   end

   // ****************************************
   // read port
   // ****************************************

   // read data stand one cycle after the strobe
   always @(posedge clock) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `FPS_OFS_CONFIG: reg_rdata <= {cfg_q, 6'h00};
            `FPS_OFS_PROTECT: reg_rdata <= prot_q;
            `FPS_OFS_STATUS: reg_rdata <= {be_q, cc_q, pv_q, ae_q, 1'b0, blank_q,
               special_mode && fail_q, special_mode && !active_q};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

// ===== pkg/fps_map.vh
// Purpose: offsets, field positions and reset values of the flash protect block
// Assumes: byte-wide registers on a plain strobe port
// Notes: included by bare name from every design file
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define FPS_OFS_CONFIG 4'h3
`define FPS_OFS_PROTECT 4'h4
`define FPS_OFS_STATUS 4'h5

// ****************************************
// protect_reg fields
// ****************************************
`define FPS_PR_OPEN 7
`define FPS_PR_HOFF 5
`define FPS_PR_HS_HI 4
`define FPS_PR_HS_LO 3
`define FPS_PR_LOFF 2
`define FPS_PR_LS_HI 1
`define FPS_PR_LS_LO 0

// ****************************************
// cmd_status_reg fields
// ****************************************
`define FPS_ST_BE 7
`define FPS_ST_CC 6
`define FPS_ST_PV 5
`define FPS_ST_AE 4
`define FPS_ST_BLANK 2
`define FPS_ST_FAIL 1
`define FPS_ST_DONE 0

// ****************************************
// flash_config_reg fields
// ****************************************
`define FPS_CF_BEIE 7
`define FPS_CF_CMD_COMPLETE_IRQ_EN 6

// ****************************************
// window bounds
// ****************************************
`define FPS_HI_START_00 16'hF800
`define FPS_HI_START_01 16'hF000
`define FPS_HI_START_10 16'hE000
`define FPS_HI_START_11 16'hC000
`define FPS_LO_START 16'h4000
`define FPS_LO_END_00 16'h43FF
`define FPS_LO_END_01 16'h47FF
`define FPS_LO_END_10 16'h4FFF
`define FPS_LO_END_11 16'h5FFF

// ****************************************
// scenario transitions, bit from*8+to
// ****************************************
`define FPS_TRANS_OK 64'hFF5A3C18080C0A0F

// ****************************************
// reset values
// ****************************************
`define FPS_RST_PROTECT 8'hFF
`define FPS_RST_CONFIG 8'h00

`endif

// ===== verilog/fps_prot_dec.v
// Purpose: decide whether a flash address lies in protected space
// Assumes: protection fields come from the protect register
// Notes: purely combinational, caller feeds the answer unregistered into its launch check
`include "fps_map.vh"

module fps_prot_dec #(
   parameter AW = 16
) (
   input wire open_polarity,
   input wire high_range_off,
   input wire [1:0] high_size_sel,
   input wire low_range_off,
   input wire [1:0] low_size_sel,
   input wire [AW-1:0] addr,
   output reg is_protected
);

   reg [AW-1:0] hi_start;
   reg [AW-1:0] lo_end;
   reg hi_hit;
   reg lo_hit;
   reg win_on;

   // ****************************************
   // window decode
   // ****************************************

   // window bounds, then polarity
   always @* begin
      case (high_size_sel)
         2'b00: hi_start = `FPS_HI_START_00;
         2'b01: hi_start = `FPS_HI_START_01;
         2'b10: hi_start = `FPS_HI_START_10;
         default: hi_start = `FPS_HI_START_11;
      endcase
      case (low_size_sel)
         2'b00: lo_end = `FPS_LO_END_00;
         2'b01: lo_end = `FPS_LO_END_01;
         2'b10: lo_end = `FPS_LO_END_10;
         default: lo_end = `FPS_LO_END_11;
      endcase
      hi_hit = (addr >= hi_start);
      lo_hit = (addr >= `FPS_LO_START) && (addr <= lo_end);
      win_on = (!high_range_off && hi_hit) || (!low_range_off && lo_hit);
      if (open_polarity) begin
         is_protected = win_on;
      end else if (high_range_off && low_range_off) begin
         is_protected = 1'b1;
      end else begin
         is_protected = !win_on;
      end
   end

endmodule

// ===== testbench/fps_top_properties.sv
// Purpose: port-level temporal checks for the flash protect block
// Assumes: one clock, synchronous active-low reset
// Notes: internal flags are invisible here, so checks tie outputs to bus causes
module fps_top_properties #(
   parameter AW = 16,
   parameter RAW = 4
) (
   input wire clock,
   input wire rstn,
   input wire special_mode,
   input wire [7:0] nvm_prot,
   input wire [RAW-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire flash_wr,
   input wire [AW-1:0] flash_wr_addr,
   input wire cmd_done,
   input wire verify_blank,
   input wire cmd_start,
   input wire [AW-1:0] cmd_start_addr,
   input wire [2:0] scenario,
   input wire irq_buf_empty,
   input wire irq_cmd_complete
);
   timeunit 1ns;
   timeprecision 1ps;
   // legal steps, bit index is from*8+to
   localparam logic [63:0] OK_TBL = 64'hFF5A3C18080C0A0F;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // ****************************************
   // register port
   // ****************************************
   // idle read data
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_st_zero: assert property (reg_rd && reg_addr == 4'h5 && !special_mode |=>
      {reg_rdata[3], reg_rdata[1:0]} == 3'h0) else $error("normal status bits not zero");
   a_scn_read: assert property (reg_rd && reg_addr == 4'h4 |=>
      scenario == {reg_rdata[7], reg_rdata[2], reg_rdata[5]}) else $error("protect readback");
   // ****************************************
   // protection scenario
   // ****************************************
   // only listed steps
   a_scn_legal: assert property (OK_TBL[{$past(scenario), scenario}])
      else $error("illegal scenario step");
   // changes only by load or protect write
   a_scn_cause: assert property ($changed(scenario) |-> !$past(rstn, 2) ||
      $past(reg_wr && reg_addr == 4'h4)) else $error("scenario changed without write");
   // ****************************************
   // command flags
   // ****************************************
   // start needs launch or finish
   a_start_why: assert property (cmd_start |-> $past(cmd_done) ||
      $past(reg_wr && reg_addr == 4'h5 && reg_wdata[7])) else $error("start without cause");
   a_cc_clear: assert property (cmd_start && !cmd_done ##1 !cmd_done [*2] |->
      !irq_cmd_complete) else $error("complete request stays on after start");
   a_be_irq_off: assert property (reg_wr && reg_addr == 4'h3 && !reg_wdata[7] |=>
      ##1 !irq_buf_empty) else $error("empty request with enable off");
   a_cc_irq_off: assert property (reg_wr && reg_addr == 4'h3 && !reg_wdata[6] |=>
      ##1 !irq_cmd_complete) else $error("complete request with enable off");
   c_start: cover property (cmd_start);
   c_prot_rd: cover property (reg_rd && reg_addr == 4'h4);
   c_both_irq: cover property (irq_buf_empty && irq_cmd_complete);
endmodule

// ===== testbench/fps_top_tb.sv
// Purpose: directed bench for protection and command status behaviour
// Assumes: bench acts as cpu bus master and as sequencer
// Notes: each protection case starts from a fresh reset
module fps_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam AW = 16;
   localparam RAW = 4;
   localparam [63:0] OK_TBL = 64'hFF5A3C18080C0A0F;
   reg clock = 1'h0;
   reg rstn = 1'h0;
   reg special_mode = 1'h0;
   reg [7:0] nvm_prot = 8'hFF;
   reg [RAW-1:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'h0;
   reg reg_rd = 1'h0;
   reg flash_wr = 1'h0;
   reg [AW-1:0] flash_wr_addr = 16'h0000;
   reg cmd_done = 1'h0;
   reg verify_blank = 1'h0;
   wire [7:0] reg_rdata;
   wire cmd_start;
   wire [AW-1:0] cmd_start_addr;
   wire [2:0] scenario;
   wire irq_buf_empty;
   wire irq_cmd_complete;
   int fail_count = 0;
   int n_tests = 0;
   fps_top #(.AW(AW), .RAW(RAW)) uut (.clock(clock), .rstn(rstn), .special_mode(special_mode),
      .nvm_prot(nvm_prot), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_wr(flash_wr),
      .flash_wr_addr(flash_wr_addr), .cmd_done(cmd_done), .verify_blank(verify_blank),
      .cmd_start(cmd_start), .cmd_start_addr(cmd_start_addr), .scenario(scenario),
      .irq_buf_empty(irq_buf_empty), .irq_cmd_complete(irq_cmd_complete));
   // 50 MHz
   always #10 clock = ~clock;
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset(input [7:0] nv, input sm);
      @(posedge clock);
      rstn <= 1'h0;
      nvm_prot <= nv;
      special_mode <= sm;
      repeat (6) @(posedge clock);
      rstn <= 1'h1;
      // load edge passes before any request
      @(posedge clock);
   endtask
   task automatic wr(input [RAW-1:0] a, input [7:0] d);
      @(posedge clock);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input [RAW-1:0] a, input [7:0] exp, input string what);
      @(posedge clock);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'h0;
      #1 chk(what, {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   task automatic done(input vb);
      @(posedge clock);
      cmd_done <= 1'h1;
      verify_blank <= vb;
      @(posedge clock);
      cmd_done <= 1'h0;
   endtask
   // word write then launch; start seen one cycle after the launch write
   task automatic launch(input [AW-1:0] a, input e);
      @(posedge clock);
      flash_wr <= 1'h1;
      flash_wr_addr <= a;
      @(posedge clock);
      flash_wr <= 1'h0;
      wr(4'h5, 8'h80);
      #1 chk("start", {15'h0000, e}, {15'h0000, cmd_start});
      if (e)
         chk("start addr", a, cmd_start_addr);
   endtask
   // fresh reset with a protect byte, then one launch
   task automatic pchk(input [7:0] nv, input [AW-1:0] a, input e);
      do_reset(nv, 1'h0);
      launch(a, e);
      if (!e)
         rd(4'h5, 8'hE0, "violation status");
   endtask
   task automatic wrap_up;
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // {open,1,off_h,size_h,off_l,size_l}; off_h is scenario bit 0, off_l bit 1
   function automatic [7:0] enc(input [2:0] s, input [1:0] zh, input [1:0] zl);
      enc = {s[2], 1'h1, s[0], zh, s[1], zl};
   endfunction
   // ****************************************
   // tests
   // ****************************************
   initial begin : main
      int f;
      int t;
      reg ok;
      for (f = 0; f < 8; f++) begin
         for (t = 0; t < 8; t++) begin
            do_reset(enc(f, 2'h1, 2'h1), 1'h0);
            wr(4'h4, enc(t, 2'h2, 2'h2));
            ok = OK_TBL[f * 8 + t];
            // size fields move only where the stored off bit was set
            rd(4'h4, ok ? enc(t, f[0] ? 2'h2 : 2'h1, f[1] ? 2'h2 : 2'h1)
               : enc(f, 2'h1, 2'h1), "protect");
            chk("scenario", ok ? t : f, {13'h0000, scenario});
         end
      end
      pchk(8'hFF, 16'hF800, 1'h1);
      pchk(8'hCF, 16'hF000, 1'h0);
      pchk(8'hCF, 16'hEFFF, 1'h1);
      pchk(8'hD7, 16'hE000, 1'h0);
      pchk(8'hD7, 16'hDFFF, 1'h1);
      pchk(8'hF9, 16'h47FF, 1'h0);
      pchk(8'hF9, 16'h4800, 1'h1);
      pchk(8'hFA, 16'h4FFF, 1'h0);
      pchk(8'hFA, 16'h5000, 1'h1);
      pchk(8'hDB, 16'hC000, 1'h0);
      pchk(8'hDB, 16'h5FFF, 1'h0);
      pchk(8'hDB, 16'h6000, 1'h1);
      pchk(8'h7F, 16'h8000, 1'h0);
      pchk(8'h40, 16'hF800, 1'h1);
      pchk(8'h40, 16'hF7FF, 1'h0);
      pchk(8'h40, 16'h43FF, 1'h1);
      pchk(8'h40, 16'h4400, 1'h0);
      pchk(8'h47, 16'h4000, 1'h0);
      pchk(8'h47, 16'hF800, 1'h1);
      do_reset(8'hFF, 1'h0);
      rd(4'h5, 8'hC0, "status reset");
      wr(4'h5, 8'h4F);
      rd(4'h5, 8'hC0, "status ro bits");
      wr(4'h5, 8'h80);
      rd(4'h5, 8'hD0, "status stray launch");
      wr(4'h5, 8'h10);
      rd(4'h5, 8'hC0, "status error clear");
      // only the upper window stays writable
      wr(4'h4, 8'h4F);
      launch(16'h0000, 1'h0);
      rd(4'h5, 8'hE0, "status violation");
      // a set violation blocks even a writable address
      launch(16'hF800, 1'h0);
      rd(4'h5, 8'hE0, "status blocked");
      wr(4'h5, 8'h20);
      launch(16'hF800, 1'h1);
      do_reset(8'hFF, 1'h0);
      @(posedge clock);
      flash_wr <= 1'h1;
      flash_wr_addr <= 16'hF800;
      @(posedge clock);
      flash_wr <= 1'h0;
      wr(4'h5, 8'h00);
      rd(4'h5, 8'hD0, "status abort");
      wr(4'h5, 8'h10);
      wr(4'h3, 8'hC0);
      rd(4'h3, 8'hC0, "config on");
      launch(16'hF800, 1'h1);
      rd(4'h5, 8'h80, "status active");
      chk("irq pair", 16'h0002, {14'h0000, irq_buf_empty, irq_cmd_complete});
      launch(16'hF000, 1'h0);
      rd(4'h5, 8'h00, "status pending");
      chk("irq pair", 16'h0000, {14'h0000, irq_buf_empty, irq_cmd_complete});
      done(1'h0);
      #1 chk("pending start", 16'hF000, cmd_start ? cmd_start_addr : 16'h0000);
      rd(4'h5, 8'h80, "status fetch");
      done(1'h1);
      rd(4'h5, 8'hC4, "status complete");
      chk("irq pair", 16'h0003, {14'h0000, irq_buf_empty, irq_cmd_complete});
      wr(4'h3, 8'h00);
      rd(4'h3, 8'h00, "config off");
      chk("irq pair", 16'h0000, {14'h0000, irq_buf_empty, irq_cmd_complete});
      do_reset(8'hFF, 1'h1);
      rd(4'h5, 8'hC1, "special idle");
      launch(16'hF800, 1'h1);
      rd(4'h5, 8'h80, "special active");
      done(1'h0);
      rd(4'h5, 8'hC3, "special fail");
      wr(4'h5, 8'h01);
      rd(4'h5, 8'hC3, "special done ro");
      // fail cleared before any new sequence
      wr(4'h5, 8'h02);
      rd(4'h5, 8'hC1, "special fail clear");
      wrap_up;
   end
   // cut short a hang at some thirteen times the expected run
   initial begin
      #300000;
      fail_count++;
      wrap_up;
   end
endmodule
bind fps_top fps_top_properties #(.AW(AW), .RAW(RAW)) u_props (.clock(clock), .rstn(rstn),
   .special_mode(special_mode), .nvm_prot(nvm_prot), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .flash_wr(flash_wr), .flash_wr_addr(flash_wr_addr), .cmd_done(cmd_done),
   .verify_blank(verify_blank), .cmd_start(cmd_start), .cmd_start_addr(cmd_start_addr),
   .scenario(scenario), .irq_buf_empty(irq_buf_empty), .irq_cmd_complete(irq_cmd_complete));
